// file: dv/dcmc_datapath_model.sv
// Converter datapath model: finishes each measurement after a delay.
// Assumes the sequencer outputs of dcmc_top drive it.
`timescale 1ns/1ps
`default_nettype none

module dcmc_datapath_model (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Sequencer view
  input  wire logic seq_busy_i,
  input  wire logic chan_b_i,
  input  wire logic slow_i,
  // Completion
  output logic      meas_done_o
);
  logic [3:0] cnt_r;
  logic       chan_q_r;

  // Restart on channel change, so one pulse per measurement only
  always_ff @(posedge core_clk_i) begin
    chan_q_r <= chan_b_i;
    if (!rst_n_i || !seq_busy_i || chan_q_r != chan_b_i) cnt_r <= 4'h0;
    else if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
    meas_done_o <= rst_n_i && seq_busy_i && cnt_r == (slow_i ? 4'h9 : 4'h2);
  end
endmodule : dcmc_datapath_model
`default_nettype wire

// file: dv/dcmc_properties.sv
// Checker for the channel configuration block.
// Assumes binding to dcmc_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dcmc_defs.svh"

module dcmc_properties (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // Inputs watched
  input wire logic        wr_done_i,
  input wire logic        wr_ok_i,
  input wire logic [3:0]  wr_addr_i,
  input wire logic [16:0] wr_data_i,
  input wire logic [3:0]  rd_addr_i,
  input wire logic        chop_en_i,
  input wire logic        dechop_en_i,
  input wire logic        seq_mode_i,
  input wire logic        seq_start_i,
  input wire logic        meas_done_i,
  // Outputs watched
  input wire logic [16:0] rd_data_o,
  input wire logic        meas_chan_b_o,
  input wire logic        seq_busy_o,
  input wire logic [16:0] active_cfg_o,
  input wire logic [4:0]  path_sw_o,
  input wire logic [3:0]  cal_idx_o,
  input wire logic        cal_fixed_o,
  input wire logic [6:0]  gain_o,
  input wire logic [12:0] osf_ext_khz_o,
  input wire logic [12:0] osf_int_khz_o,
  input wire logic [7:0]  osr_o,
  input wire logic [3:0]  chop_ratio_o,
  input wire logic [10:0] avg_count_o,
  input wire logic        raw_mode_o,
  input wire logic        avg_test_o,
  input wire logic [4:0]  raw_shift_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_wr_a;
    wr_done_i && wr_ok_i && wr_addr_i == `DCMC_ADDR_CHAN_A && rd_addr_i == `DCMC_ADDR_CHAN_A;
  endsequence
  sequence s_hold_rd_a;
    rd_addr_i == `DCMC_ADDR_CHAN_A && !wr_done_i;
  endsequence
  sequence s_a_done;
    seq_busy_o && !meas_chan_b_o && meas_done_i;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_path; path_sw_o == active_cfg_o[13:9]; endproperty
  property p_cal;
    active_cfg_o[9] ? (cal_idx_o == {2'h0, active_cfg_o[8:7]} && !cal_fixed_o) :
    (active_cfg_o[16:14] > 3'h5 ? cal_fixed_o : (cal_idx_o == 4'h4 + active_cfg_o[16:14] && !cal_fixed_o));
  endproperty
  property p_gain;
    gain_o == (active_cfg_o[8] ? (active_cfg_o[7] ? `DCMC_GAIN_100 : `DCMC_GAIN_50)
                               : (active_cfg_o[7] ? `DCMC_GAIN_24 : `DCMC_GAIN_6));
  endproperty
  property p_osf;
    osf_ext_khz_o == (active_cfg_o[6] ? 13'h1000 : 13'h0800) && osf_int_khz_o == (active_cfg_o[6] ? 13'h0108 : 13'h0084);
  endproperty
  property p_osr; osr_o == (active_cfg_o[5] ? 8'h80 : 8'h40); endproperty
  property p_chop_on; (chop_en_i || dechop_en_i)[*3] |-> chop_ratio_o == (active_cfg_o[4] ? 4'h8 : 4'h4); endproperty
  property p_chop_off; (!chop_en_i && !dechop_en_i)[*3] |-> chop_ratio_o == 4'h1; endproperty
  property p_avg;
    avg_count_o == (active_cfg_o[3:0] <= 4'ha ? 11'h001 << active_cfg_o[3:0] : 11'h001) &&
    avg_test_o == (active_cfg_o[3:0] > 4'ha && active_cfg_o[3:0] != 4'hf);
  endproperty
  property p_raw; raw_mode_o == (active_cfg_o[3:0] == 4'hf) && raw_shift_o == (active_cfg_o[5] ? 5'h11 : 5'h0e); endproperty
  property p_wr_a; s_wr_a ##1 s_hold_rd_a |=> rd_data_o == $past(wr_data_i, 2); endproperty
  // Status flops lag the sequencer state by one edge
  property p_seq_start; !seq_busy_o && seq_mode_i && seq_start_i |-> ##2 seq_busy_o && !meas_chan_b_o; endproperty
  property p_seq_ab; s_a_done |-> ##2 meas_chan_b_o; endproperty

  a_path:      assert property (p_path)      else $error("path switches differ from field");
  a_cal:       assert property (p_cal)       else $error("calibration select wrong");
  a_gain:      assert property (p_gain)      else $error("gain wrong");
  a_osf:       assert property (p_osf)       else $error("oversampling frequency wrong");
  a_osr:       assert property (p_osr)       else $error("oversampling ratio wrong");
  a_chop_on:   assert property (p_chop_on)   else $error("chop ratio wrong");
  a_chop_off:  assert property (p_chop_off)  else $error("chop ratio not one");
  a_avg:       assert property (p_avg)       else $error("averaging count wrong");
  a_raw:       assert property (p_raw)       else $error("raw mode or shift wrong");
  a_wr_a:      assert property (p_wr_a)      else $error("write not seen on read");
  a_seq_start: assert property (p_seq_start) else $error("sequence did not start on A");
  a_seq_ab:    assert property (p_seq_ab)    else $error("sequence did not move to B");
endmodule : dcmc_properties

bind dcmc_top dcmc_properties dcmc_properties_inst (.core_clk_i, .rst_n_i, .wr_done_i, .wr_ok_i, .wr_addr_i,
  .wr_data_i, .rd_addr_i, .chop_en_i, .dechop_en_i, .seq_mode_i, .seq_start_i, .meas_done_i, .rd_data_o,
  .meas_chan_b_o, .seq_busy_o, .active_cfg_o, .path_sw_o, .cal_idx_o, .cal_fixed_o, .gain_o, .osf_ext_khz_o,
  .osf_int_khz_o, .osr_o, .chop_ratio_o, .avg_count_o, .raw_mode_o, .avg_test_o, .raw_shift_o);
`default_nettype wire

// file: dv/dcmc_top_tb.sv
// Self-checking bench for dcmc_top with a datapath model.
// Assumes checker bound separately; 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module dcmc_top_tb;
  import dcmc_pkg::*;
  logic core_clk_i, rst_n_i, wr_done_i, wr_ok_i, chop_en_i, dechop_en_i;
  logic seq_mode_i, seq_start_i, meas_done_i, use_chan_b_i, slow_r, meas_chan_b_o, seq_busy_o;
  logic cal_fixed_o, raw_mode_o, avg_test_o;
  logic [3:0] wr_addr_i, rd_addr_i, seq_len_i, cal_idx_o, chop_ratio_o;
  logic [16:0] wr_data_i, rd_data_o, active_cfg_o;
  logic [4:0] path_sw_o, raw_shift_o;
  logic [6:0] gain_o;
  logic [12:0] osf_ext_khz_o, osf_int_khz_o;
  logic [7:0] osr_o;
  logic [10:0] avg_count_o;
  dcmc_route_t route_o;
  int bad_count, n_checks;

  dcmc_top dcmc_top_inst (.core_clk_i, .rst_n_i, .wr_done_i, .wr_ok_i, .wr_addr_i, .wr_data_i, .rd_addr_i,
    .rd_data_o, .chop_en_i, .dechop_en_i, .seq_len_i, .seq_mode_i, .seq_start_i, .meas_done_i, .use_chan_b_i,
    .meas_chan_b_o, .seq_busy_o, .active_cfg_o, .path_sw_o, .route_o, .cal_idx_o, .cal_fixed_o, .gain_o,
    .osf_ext_khz_o, .osf_int_khz_o, .osr_o, .chop_ratio_o, .avg_count_o, .raw_mode_o, .avg_test_o, .raw_shift_o);
  dcmc_datapath_model dcmc_datapath_model_inst (.core_clk_i, .rst_n_i, .seq_busy_i(seq_busy_o),
    .chan_b_i(meas_chan_b_o), .slow_i(slow_r), .meas_done_o(meas_done_i));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  // Leaves the strobe high so back-to-back writes never glitch it
  task automatic wr(input logic [3:0] a, input logic [16:0] d, input logic ok);
    wr_done_i = 1'b1; wr_ok_i = ok; wr_addr_i = a; wr_data_i = d;
    tick(1);
  endtask : wr
  task automatic lda(input logic [16:0] d);
    rd_addr_i = 4'h1;
    wr(4'h1, d, 1'b1);
    wr_done_i = 1'b0;
    tick(3);
  endtask : lda
  task automatic rdchk(input logic [3:0] a, input logic [16:0] exp);
    rd_addr_i = a;
    tick(1);
    chk("rd_data", rd_data_o, exp);
  endtask : rdchk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(4'h1, 17'h003c0);
    rdchk(4'h2, 17'h018c0);
    chk("path", path_sw_o, 5'h01);
    chk("cal", cal_idx_o, 4'h3);
    chk("gain", gain_o, 7'h64);
    chk("osr", osr_o, 8'h40);
    chk("avg", avg_count_o, 11'h001);
  endtask : t_reset
  task automatic t_regs();
    wr(4'h1, 17'h15939, 1'b1);
    wr(4'h2, 17'h0a4cf, 1'b1);
    wr(4'h1, 17'h003c0, 1'b0);
    wr(4'h3, 17'h003c0, 1'b1);
    wr_done_i = 1'b0;
    tick(3);
    rdchk(4'h1, 17'h15939);
    rdchk(4'h2, 17'h0a4cf);
    rdchk(4'h3, 17'h00000);
    chk("cal_a", cal_idx_o, 4'h9);
    chk("chop_a", chop_ratio_o, 4'h8);
    chk("avg_a", avg_count_o, 11'h200);
    use_chan_b_i = 1'b1;
    tick(3);
    chk("cfg_b", active_cfg_o, 17'h0a4cf);
    chk("gain_b", gain_o, 7'h18);
    chk("route_b", route_o, DCMC_ROUTE_U1_TMP);
    chk("raw_b", raw_mode_o, 1'b1);
    use_chan_b_i = 1'b0;
    tick(3);
  endtask : t_regs
  task automatic t_cal();
    for (int c = 0; c < 8; c++) begin
      lda({c[2:0], 5'h08, 2'h0, 3'h4, 4'h0});
      chk("fixed", cal_fixed_o, c > 5);
      if (c < 6) chk("cal_u", cal_idx_o, 4'h4 + c[3:0]);
    end
    for (int g = 0; g < 4; g++) begin
      lda({3'h7, 5'h01, g[1:0], 7'h40});
      chk("cal_i", cal_idx_o, g[3:0]);
      chk("gain", gain_o, g == 0 ? 7'h06 : g == 1 ? 7'h18 : g == 2 ? 7'h32 : 7'h64);
    end
  endtask : t_cal
  task automatic t_avg();
    for (int r = 0; r < 2; r++)
      for (int n = 0; n < 16; n++) begin
        lda({3'h0, 5'h08, 2'h3, 1'b1, r[0], 1'b0, n[3:0]});
        chk("avg", avg_count_o, n <= 10 ? 11'h001 << n : 11'h001);
        chk("test", avg_test_o, n > 10 && n < 15);
        chk("raw", raw_mode_o, n == 15);
        chk("shift", raw_shift_o, r ? 5'h11 : 5'h0e);
        chk("osr", osr_o, r ? 8'h80 : 8'h40);
      end
  endtask : t_avg
  task automatic t_paths();
    logic [4:0] pats[7];
    dcmc_route_t rts[7];
    pats = '{5'h01, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14};
    rts = '{DCMC_ROUTE_SHUNT, DCMC_ROUTE_VBUS, DCMC_ROUTE_VBUS_TMP, DCMC_ROUTE_VBUS_RSL,
            DCMC_ROUTE_U1, DCMC_ROUTE_U1_TMP, DCMC_ROUTE_U1_RSL};
    for (int i = 0; i < 7; i++) begin
      lda({3'h0, pats[i], 2'h3, 3'h4, 4'h0});
      chk("path", path_sw_o, pats[i]);
      chk("route", route_o, rts[i]);
    end
  endtask : t_paths
  task automatic t_chop();
    for (int m = 0; m < 8; m++) begin
      {chop_en_i, dechop_en_i} = m[1:0];
      lda({3'h0, 5'h08, 2'h3, m[2], 1'b0, m[2], 4'h0});
      chk("chop", chop_ratio_o, m[1:0] == 2'h0 ? 4'h1 : m[2] ? 4'h8 : 4'h4);
      chk("osf_ext", osf_ext_khz_o, m[2] ? 13'h1000 : 13'h0800);
      chk("osf_int", osf_int_khz_o, m[2] ? 13'h0108 : 13'h0084);
    end
  endtask : t_chop
  task automatic t_seq(input logic [3:0] len, input logic slow);
    int flips;
    int k;
    logic prev;
    flips = 0;
    prev = 1'b0;
    seq_len_i = len; slow_r = slow; seq_mode_i = 1'b1; seq_start_i = 1'b1;
    tick(1);
    seq_start_i = 1'b0;
    tick(1);
    chk("busy", seq_busy_o, 1'b1);
    chk("first_a", meas_chan_b_o, 1'b0);
    for (k = 0; k < 400 && seq_busy_o === 1'b1; k++) begin
      if (meas_chan_b_o !== prev) flips++;
      prev = meas_chan_b_o;
      if (meas_chan_b_o === 1'b1 && active_cfg_o !== 17'h0a4cf) chk("cfg_b", active_cfg_o, 17'h0a4cf);
      tick(1);
    end
    if (k == 400) begin
      bad_count++;
      tally_and_finish();
    end
    chk("flips", flips, 2 * len - 1);
    seq_mode_i = 1'b0;
    tick(2);
  endtask : t_seq

  initial begin
    {wr_done_i, wr_ok_i, seq_mode_i, seq_start_i, use_chan_b_i, slow_r} = '0;
    {chop_en_i, dechop_en_i} = 2'h3;
    wr_addr_i = 4'h0; rd_addr_i = 4'h0; wr_data_i = '0; seq_len_i = 4'h1;
    rst_n_i = 1'b0;
    tick(3);
    rst_n_i = 1'b1;
    t_reset();
    t_regs();
    t_seq(4'h2, 1'b0);
    t_seq(4'h1, 1'b1);
    t_cal();
    t_avg();
    t_paths();
    t_chop();
    tally_and_finish();
  end
endmodule : dcmc_top_tb
`default_nettype wire

// file: hw/dcmc_defs.svh
// Constants for the dual channel measurement configuration block.
// Assumes inclusion by bare name from the package and the main module.
`ifndef DCMC_DEFS_SVH
`define DCMC_DEFS_SVH

// ----------------------------------------
// Register addresses and width
// ----------------------------------------
`define DCMC_ADDR_W          4
`define DCMC_ADDR_CHAN_A     4'h1
`define DCMC_ADDR_CHAN_B     4'h2
`define DCMC_CFG_W           17

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCMC_CALSEL_HI       16
`define DCMC_CALSEL_LO       14
`define DCMC_PATH_HI         13
`define DCMC_PATH_LO         9
`define DCMC_CURRENT_BIT     9
`define DCMC_GAIN_HI         8
`define DCMC_GAIN_LO         7
`define DCMC_OSF_BIT         6
`define DCMC_OSR_BIT         5
`define DCMC_CHOP_BIT        4
`define DCMC_AVG_HI          3
`define DCMC_AVG_LO          0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DCMC_CHAN_A_RST      17'h003c0
`define DCMC_CHAN_B_RST      17'h018c0

// ----------------------------------------
// Field encodings
// ----------------------------------------
`define DCMC_PATH_SHUNT      5'h01
`define DCMC_PATH_VBUS       5'h08
`define DCMC_PATH_VBUS_TEMP  5'h0a
`define DCMC_PATH_VBUS_RSL   5'h0c
`define DCMC_PATH_U1         5'h10
`define DCMC_PATH_U1_TEMP    5'h12
`define DCMC_PATH_U1_RSL     5'h14
`define DCMC_AVG_RAW         4'hf
`define DCMC_AVG_MAX         4'ha
`define DCMC_FIXED_CAL       11'h60c
`define DCMC_GAIN_6          7'h06
`define DCMC_GAIN_24         7'h18
`define DCMC_GAIN_50         7'h32
`define DCMC_GAIN_100        7'h64
`define DCMC_OSR_64          8'h40
`define DCMC_OSR_128         8'h80
`define DCMC_CHOP_1          4'h1
`define DCMC_CHOP_4          4'h4
`define DCMC_CHOP_8          4'h8
`define DCMC_RAW_X_64        5'h03
`define DCMC_RAW_X_128       5'h06
`define DCMC_RAW_BASE        5'h0b
`define DCMC_OSF_EXT_LO_KHZ  13'h0800
`define DCMC_OSF_EXT_HI_KHZ  13'h1000
`define DCMC_OSF_INT_LO_KHZ  13'h0084
`define DCMC_OSF_INT_HI_KHZ  13'h0108

`endif

// file: hw/dcmc_field_decode.sv
// Decoder from one channel configuration word to analog and filter controls.
// Assumes a stable input word; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "dcmc_defs.svh"

module dcmc_field_decode (
  // Configuration in
  input  wire logic               [16:0] cfg_i,
  input  wire logic                      chop_en_i,
  input  wire logic                      dechop_en_i,
  // Decoded controls
  output logic                    [4:0]  path_sw_o,
  output dcmc_pkg::dcmc_route_t          route_o,
  output logic                    [3:0]  cal_idx_o,
  output logic                           cal_fixed_o,
  output logic                    [6:0]  gain_o,
  output logic                    [12:0] osf_ext_khz_o,
  output logic                    [12:0] osf_int_khz_o,
  output logic                    [7:0]  osr_o,
  output logic                    [3:0]  chop_ratio_o,
  output logic                    [10:0] avg_count_o,
  output logic                           raw_mode_o,
  output logic                           avg_test_o,
  output logic                    [4:0]  raw_shift_o
);
  import dcmc_pkg::*;

  logic [2:0] volt_calib_select;
  logic [1:0] gain_select;
  logic [3:0] average_count_sel;
  logic       current_path_switch;

  assign volt_calib_select   = cfg_i[`DCMC_CALSEL_HI:`DCMC_CALSEL_LO];
  assign gain_select         = cfg_i[`DCMC_GAIN_HI:`DCMC_GAIN_LO];
  assign average_count_sel   = cfg_i[`DCMC_AVG_HI:`DCMC_AVG_LO];
  assign current_path_switch = cfg_i[`DCMC_CURRENT_BIT];

  // Switch bits drive the mux directly, positive logic
  assign path_sw_o = cfg_i[`DCMC_PATH_HI:`DCMC_PATH_LO]; // R4

  always_comb begin
    case (path_sw_o)
      `DCMC_PATH_SHUNT:     route_o = DCMC_ROUTE_SHUNT;    // R6
      `DCMC_PATH_VBUS:      route_o = DCMC_ROUTE_VBUS;     // R6
      `DCMC_PATH_VBUS_TEMP: route_o = DCMC_ROUTE_VBUS_TMP; // R6
      `DCMC_PATH_VBUS_RSL:  route_o = DCMC_ROUTE_VBUS_RSL; // R6
      `DCMC_PATH_U1:        route_o = DCMC_ROUTE_U1;       // R7
      `DCMC_PATH_U1_TEMP:   route_o = DCMC_ROUTE_U1_TMP;   // R7
      `DCMC_PATH_U1_RSL:    route_o = DCMC_ROUTE_U1_RSL;   // R7
      default:              route_o = DCMC_ROUTE_ILLEGAL;  // R8
    endcase
  end

  // Index 0..3 current constants, 4..9 voltage constants
  always_comb begin
    cal_fixed_o = 1'b0;
    if (current_path_switch) begin
      cal_idx_o = {2'b00, gain_select}; // R17
    end else if (volt_calib_select[2] && volt_calib_select[1]) begin
      cal_idx_o   = 4'h4;
      cal_fixed_o = 1'b1; // R5
    end else begin
      cal_idx_o = 4'h4 + {1'b0, volt_calib_select}; // R5
    end
  end

  always_comb begin
    case (gain_select)
      2'h0:    gain_o = `DCMC_GAIN_6;   // R9
      2'h1:    gain_o = `DCMC_GAIN_24;  // R9
      2'h2:    gain_o = `DCMC_GAIN_50;  // R9
      default: gain_o = `DCMC_GAIN_100; // R9
    endcase
  end

  assign osf_ext_khz_o = cfg_i[`DCMC_OSF_BIT] ? `DCMC_OSF_EXT_HI_KHZ : `DCMC_OSF_EXT_LO_KHZ; // R10
  assign osf_int_khz_o = cfg_i[`DCMC_OSF_BIT] ? `DCMC_OSF_INT_HI_KHZ : `DCMC_OSF_INT_LO_KHZ; // R10
  assign osr_o         = cfg_i[`DCMC_OSR_BIT] ? `DCMC_OSR_128 : `DCMC_OSR_64;                // R11

  // Both enables off makes every cycle active
  always_comb begin
    if (!chop_en_i && !dechop_en_i) begin
      chop_ratio_o = `DCMC_CHOP_1; // R13
    end else begin
      chop_ratio_o = cfg_i[`DCMC_CHOP_BIT] ? `DCMC_CHOP_8 : `DCMC_CHOP_4; // R12
    end
  end

  assign raw_mode_o  = (average_count_sel == `DCMC_AVG_RAW);                    // R15
  assign avg_test_o  = (average_count_sel > `DCMC_AVG_MAX) && !raw_mode_o;     // R14
  // Reserved and raw codes still report one result per conversion
  assign avg_count_o = (average_count_sel > `DCMC_AVG_MAX) ? 11'h001
                     : (11'h001 << average_count_sel);                        // R14
  // Raw scale exponent 11+x; host divides by the applied constant
  assign raw_shift_o = `DCMC_RAW_BASE
                     + (cfg_i[`DCMC_OSR_BIT] ? `DCMC_RAW_X_128 : `DCMC_RAW_X_64); // R16

endmodule : dcmc_field_decode
`default_nettype wire

// file: hw/dcmc_pkg.sv
// Types for the dual channel measurement configuration block.
// Assumes dcmc_defs.svh is on the include path.
`include "dcmc_defs.svh"

package dcmc_pkg;

  typedef logic [`DCMC_CFG_W-1:0] dcmc_cfg_t;

  // Path routing decoded from the switch field
  typedef enum logic [2:0] {
    DCMC_ROUTE_SHUNT    = 3'h0,
    DCMC_ROUTE_VBUS     = 3'h1,
    DCMC_ROUTE_VBUS_TMP = 3'h3,
    DCMC_ROUTE_VBUS_RSL = 3'h2,
    DCMC_ROUTE_U1       = 3'h6,
    DCMC_ROUTE_U1_TMP   = 3'h7,
    DCMC_ROUTE_U1_RSL   = 3'h5,
    DCMC_ROUTE_ILLEGAL  = 3'h4
  } dcmc_route_t;

  // Measurement sequencer state
  typedef enum logic [1:0] {
    DCMC_SEQ_IDLE = 2'h0,
    DCMC_SEQ_A    = 2'h1,
    DCMC_SEQ_B    = 2'h3
  } dcmc_seq_t;

endpackage : dcmc_pkg

// file: hw/dcmc_top.sv
// Channel A/B measurement configuration registers with decoded controls.
// Assumes a serial front end delivering whole, accepted register words.
//
// What this block does
// [R1] Channel A seventeen bit configuration register
// [R2] Power-up defaults for both channel registers
// [R3] Channel B register identical to channel A
// [R4] Path switch bits are positive logic
// [R5] Voltage calibration select; codes six, seven fixed
// [R6] Shunt and voltage bus path patterns
// [R7] Unity gain voltage bus path patterns
// [R8] Host writes only listed path patterns
// [R9] Gain code selects 6, 24, 50, 100
// [R10] Oversampling frequency bit selects clock rate
// [R11] Oversampling ratio bit selects 64 or 128
// [R12] Chopping ratio bit selects 4 or 8
// [R13] Chop and dechop off gives ratio one
// [R14] Averaging code n up to ten averages two power n
// [R15] Averaging code fifteen selects raw mode
// [R16] Raw scale exponent eleven plus x
// [R17] Current switch selects constant by gain
// [R18] Chop enables come from general register
// [R19] Sequence mode alternates A and B measurements
// [R20] Channel registers update only after accepted writes
// [R21] Present configuration of measured channel
`timescale 1ns/1ps
`default_nettype none
`include "dcmc_defs.svh"

module dcmc_top (
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // Register write from serial front end
  input  wire logic                      wr_done_i,
  input  wire logic                      wr_ok_i,
  input  wire logic               [3:0]  wr_addr_i,
  input  wire logic               [16:0] wr_data_i,
  // Register read
  input  wire logic               [3:0]  rd_addr_i,
  output logic                    [16:0] rd_data_o,
  // General configuration bits
  input  wire logic                      chop_en_i,
  input  wire logic                      dechop_en_i,
  input  wire logic               [3:0]  seq_len_i,
  // Measurement sequencing from the converter
  input  wire logic                      seq_mode_i,
  input  wire logic                      seq_start_i,
  input  wire logic                      meas_done_i,
  input  wire logic                      use_chan_b_i,
  // Decoded controls to analog path and filter
  output logic                           meas_chan_b_o,
  output logic                           seq_busy_o,
  output logic                    [16:0] active_cfg_o,
  output logic                    [4:0]  path_sw_o,
  output dcmc_pkg::dcmc_route_t          route_o,
  output logic                    [3:0]  cal_idx_o,
  output logic                           cal_fixed_o,
  output logic                    [6:0]  gain_o,
  output logic                    [12:0] osf_ext_khz_o,
  output logic                    [12:0] osf_int_khz_o,
  output logic                    [7:0]  osr_o,
  output logic                    [3:0]  chop_ratio_o,
  output logic                    [10:0] avg_count_o,
  output logic                           raw_mode_o,
  output logic                           avg_test_o,
  output logic                    [4:0]  raw_shift_o
);
  import dcmc_pkg::*;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  dcmc_cfg_t chan_a_config_r;
  dcmc_cfg_t chan_b_config_r;

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target);
    wr_hit = wr_done_i && wr_ok_i && (a == target);
  endfunction : wr_hit

  // Only a completed and accepted write loads a register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      chan_a_config_r <= `DCMC_CHAN_A_RST; // R2
    end else if (wr_hit(wr_addr_i, `DCMC_ADDR_CHAN_A)) begin
      chan_a_config_r <= wr_data_i; // R1 R20
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      chan_b_config_r <= `DCMC_CHAN_B_RST; // R2
    end else if (wr_hit(wr_addr_i, `DCMC_ADDR_CHAN_B)) begin
      chan_b_config_r <= wr_data_i; // R3 R20
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else begin
      case (rd_addr_i)
        `DCMC_ADDR_CHAN_A: rd_data_o <= chan_a_config_r;
        `DCMC_ADDR_CHAN_B: rd_data_o <= chan_b_config_r;
        default:           rd_data_o <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // A/B sequence
  // ----------------------------------------
  // Length code 0 means sixteen pairs
  dcmc_seq_t  seq_state_r;
  logic [4:0] seq_left_r;
  logic [4:0] seq_len_full;

  assign seq_len_full = (seq_len_i == 4'h0) ? 5'h10 : {1'b0, seq_len_i};

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      seq_state_r <= DCMC_SEQ_IDLE;
      seq_left_r  <= 5'h00;
    end else begin
      case (seq_state_r)
        DCMC_SEQ_IDLE: begin
          if (seq_mode_i && seq_start_i) begin
            seq_state_r <= DCMC_SEQ_A; // R19
            seq_left_r  <= seq_len_full;
          end
        end
        DCMC_SEQ_A: begin
          if (meas_done_i) begin
            seq_state_r <= DCMC_SEQ_B; // R19
          end
        end
        DCMC_SEQ_B: begin
          if (meas_done_i) begin
            if (seq_left_r <= 5'h01) begin
              seq_state_r <= DCMC_SEQ_IDLE;
              seq_left_r  <= 5'h00;
            end else begin
              seq_state_r <= DCMC_SEQ_A; // R19
              seq_left_r  <= seq_left_r - 5'h01;
            end
          end
        end
        default: begin
          seq_state_r <= DCMC_SEQ_IDLE;
        end
      endcase
    end
  end

  logic sel_b;
  assign sel_b = (seq_state_r == DCMC_SEQ_IDLE) ? use_chan_b_i : (seq_state_r == DCMC_SEQ_B);

  // ----------------------------------------
  // Decode of the measured channel
  // ----------------------------------------
  dcmc_cfg_t   sel_cfg;
  logic [4:0]  dec_path;
  dcmc_route_t dec_route;
  logic [3:0]  dec_cal_idx;
  logic        dec_cal_fixed;
  logic [6:0]  dec_gain;
  logic [12:0] dec_osf_ext;
  logic [12:0] dec_osf_int;
  logic [7:0]  dec_osr;
  logic [3:0]  dec_chop;
  logic [10:0] dec_avg;
  logic        dec_raw;
  logic        dec_test;
  logic [4:0]  dec_shift;

  assign sel_cfg = sel_b ? chan_b_config_r : chan_a_config_r; // R21

  dcmc_field_decode u_decode (
    .cfg_i         (sel_cfg),
    .chop_en_i     (chop_en_i),   // R18
    .dechop_en_i   (dechop_en_i), // R18
    .path_sw_o     (dec_path),
    .route_o       (dec_route),
    .cal_idx_o     (dec_cal_idx),
    .cal_fixed_o   (dec_cal_fixed),
    .gain_o        (dec_gain),
    .osf_ext_khz_o (dec_osf_ext),
    .osf_int_khz_o (dec_osf_int),
    .osr_o         (dec_osr),
    .chop_ratio_o  (dec_chop),
    .avg_count_o   (dec_avg),
    .raw_mode_o    (dec_raw),
    .avg_test_o    (dec_test),
    .raw_shift_o   (dec_shift)
  );

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // One cycle behind the registers keeps every output a flop
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meas_chan_b_o <= 1'b0;
      seq_busy_o    <= 1'b0;
      active_cfg_o  <= `DCMC_CHAN_A_RST;
      path_sw_o     <= 5'h01;
      route_o       <= DCMC_ROUTE_SHUNT;
      cal_idx_o     <= 4'h3;
      cal_fixed_o   <= 1'b0;
      gain_o        <= `DCMC_GAIN_100;
      osf_ext_khz_o <= `DCMC_OSF_EXT_HI_KHZ;
      osf_int_khz_o <= `DCMC_OSF_INT_HI_KHZ;
      osr_o         <= `DCMC_OSR_64;
      chop_ratio_o  <= `DCMC_CHOP_4;
      avg_count_o   <= 11'h001;
      raw_mode_o    <= 1'b0;
      avg_test_o    <= 1'b0;
      raw_shift_o   <= 5'h0e;
    end else begin
      meas_chan_b_o <= sel_b;                          // R21
      seq_busy_o    <= (seq_state_r != DCMC_SEQ_IDLE); // R19
      active_cfg_o  <= sel_cfg;                        // R21
      path_sw_o     <= dec_path;                       // R4
      route_o       <= dec_route;                      // R6
      cal_idx_o     <= dec_cal_idx;                    // R17
      cal_fixed_o   <= dec_cal_fixed;                  // R5
      gain_o        <= dec_gain;                       // R9
      osf_ext_khz_o <= dec_osf_ext;                    // R10
      osf_int_khz_o <= dec_osf_int;                    // R10
      osr_o         <= dec_osr;                        // R11
      chop_ratio_o  <= dec_chop;                       // R12
      avg_count_o   <= dec_avg;                        // R14
      raw_mode_o    <= dec_raw;                        // R15
      avg_test_o    <= dec_test;                       // R14
      raw_shift_o   <= dec_shift;                      // R16
    end
  end

endmodule : dcmc_top
`default_nettype wire
